// ===== pkg/cfc_pkg.sv
// cfc_pkg: register map, field layout, reset values and state codes of the
// contactless front-end calibration register bank.
// assumes an AXI4-Lite master with 32-bit data; registers sit at 4 x index.
package cfc_pkg;

	// register indices; byte address is four times the index
	localparam logic [6:0] IDX_BITGRID = 7'h4E;
	localparam logic [6:0] IDX_PREPROC = 7'h4F;
	localparam logic [6:0] IDX_DET_CTL = 7'h50;
	localparam logic [6:0] IDX_IQ_RES = 7'h51;
	localparam logic [6:0] IDX_CAL_STAT = 7'h53;
	localparam logic [6:0] IDX_SUPPLY = 7'h54;
	localparam logic [6:0] IDX_REG_RDBK = 7'h56;
	localparam logic [6:0] IDX_FREQ = 7'h59;
	localparam logic [6:0] IDX_STRENGTH = 7'h5A;
	localparam logic [6:0] IDX_INTERP = 7'h5C;
	localparam logic [6:0] IDX_NOV_CAL = 7'h5D;

	// writable field masks
	localparam logic [31:0] BITGRID_MASK = 32'h00FF_FFFF;
	localparam logic [31:0] PREPROC_MASK = 32'h0000_03FF;
	localparam logic [31:0] DET_CTL_MASK = 32'h40FF_FFFF;
	localparam logic [31:0] SUPPLY_MASK = 32'h0000_00FF;
	localparam logic [31:0] NOV_CAL_MASK = 32'h0000_0003;

	// reset values
	localparam logic [23:0] BITGRID_RST = 24'h00_0000;
	localparam logic [9:0] PREPROC_RST = 10'h27C;
	localparam logic [7:0] SUPPLY_RST = 8'h00;

	// field positions
	localparam int DET_STORE_BIT = 30;
	localparam int DET_HYST_LSB = 16;
	localparam int PRE_FREEZE_BIT = 8;
	localparam int STAT_DET_BIT = 31;
	localparam int STAT_NOV_BIT = 0;

	// nonvolatile configuration locations
	localparam logic [15:0] NV_TARGET_ADDR = 16'h03E0;
	localparam logic [15:0] NV_HYST_ADDR = 16'h03E2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CAL = 2'b01,
		ST_NV_TGT = 2'b10,
		ST_NV_HYS = 2'b11
	} cfc_state_e;

endpackage : cfc_pkg

// ===== rtl/cfc_regs.sv
// cfc_regs: AXI4-Lite register bank of the contactless front-end calibration
// and measurement registers, with the card-detect calibration sequencer.
// assumes every status input comes from logic on clock_i (no synchronisers).
//
// Overview of operation
// - control write starts calibration with target, hysteresis
// - bit30 set stores values to nonvolatile instead
// - status bit31 detect done, bit0 offset done
// - successful calibration presents Q high, I low
// - supply setting drives regulator unless power control
// - supply read returns actual present setting
// - readback: current 23:8 mA, voltage code 7:0
// - carrier frequency delta, phase, valid flag readback
// - strength, attenuation, valid, freq-ok, frozen readback
// - phase freeze bit holds phase rotator value
// - window start/stop, combiner mode, sync input select
// - bit-grid filter window, rate, thresholds, delay
// - offset calibrate register write runs calibration, store
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ns
module cfc_regs #(
	parameter int ADDR_W = 9
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// AXI4-Lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// bit-grid adaptive filter settings
	output logic [3:0] threshold_half_window_o,
	output logic [3:0] threshold_update_rate_o,
	output logic [5:0] threshold_factor_min_o,
	output logic [5:0] threshold_factor_max_o,
	output logic [3:0] bitgrid_align_delay_o,
	// pre-processing
	output logic [2:0] window_start_o,
	output logic [3:0] window_stop_o,
	output logic combiner_mode_select_o,
	output logic sync_input_select_o,
	input wire logic [8:0] rotator_phase_i,
	output logic [8:0] rotator_phase_o,
	// low power card detect calibration engine
	output logic low_power_card_detect_cal_start_o,
	output logic [15:0] strength_target_o,
	output logic [7:0] strength_hysteresis_o,
	input wire logic cal_done_i,
	input wire logic cal_ok_i,
	input wire logic [15:0] inphase_value_i,
	input wire logic [15:0] quadrature_value_i,
	// nonvolatile configuration write port
	output logic nv_req_o,
	output logic [15:0] nv_addr_o,
	output logic [15:0] nv_data_o,
	input wire logic nv_ack_i,
	// transmitter offset calibration
	output logic tx_offset_calib_start_o,
	output logic [1:0] tx_offset_calib_trigger_o,
	input wire logic tx_offset_calib_end_i,
	// transmitter supply regulator
	input wire logic dynamic_power_control_en_i,
	input wire logic [7:0] dynamic_power_control_setting_i,
	output logic [7:0] tx_supply_setting_o,
	input wire logic [15:0] tx_current_measured_i,
	input wire logic [7:0] tx_supply_readback_i,
	// carrier measurement
	input wire logic freq_fields_valid_i,
	input wire logic [8:0] carrier_freq_delta_i,
	input wire logic [8:0] carrier_phase_i,
	input wire logic [13:0] strength_value_i,
	input wire logic [5:0] latched_attenuation_i,
	input wire logic strength_fields_valid_i,
	input wire logic carrier_freq_good_i,
	input wire logic strength_not_updating_i,
	input wire logic [31:0] interpolated_strength_value_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [23:0] bitgrid;
		logic [9:0] preproc;
		logic det_store;
		logic [7:0] hyst;
		logic [15:0] target;
		logic [31:0] iq;
		logic det_done;
		logic nov_done;
		logic nov_busy;
		logic nov_start;
		logic [1:0] nov_trig;
		logic [7:0] supply_cfg;
		logic [7:0] supply_out;
		logic [8:0] rot_phase;
		cfc_pkg::cfc_state_e fsm;
		logic cal_start;
		logic nv_req;
		logic [15:0] nv_addr;
		logic [15:0] nv_data;
		logic aw_full;
		logic [6:0] aw_idx;
		logic w_full;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cfc_state_s;
	cfc_state_s st_r;
	cfc_state_s st_nxt;
	logic wr_fire;
	logic ar_fire;
	logic [6:0] ar_idx;
	logic [31:0] wr_val;
	function automatic logic [31:0] cfc_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb,
			input logic [31:0] mask);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		cfc_merge = res & mask;
	endfunction : cfc_merge
	// the write is applied once both address and data are held
	assign wr_fire = st_r.aw_full && st_r.w_full && !st_r.bvalid;
	assign ar_fire = s_axi_arvalid_i && st_r.arready;
	assign ar_idx = s_axi_araddr_i[8:2];

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		wr_val = 32'h0000_0000;
		st_nxt.cal_start = 1'b0;
		st_nxt.nov_start = 1'b0;
		// write channel capture, either order
		if (s_axi_awvalid_i && st_r.awready) begin
			st_nxt.aw_full = 1'b1;
			st_nxt.aw_idx = s_axi_awaddr_i[8:2];
		end
		if (s_axi_wvalid_i && st_r.wready) begin
			st_nxt.w_full = 1'b1;
			st_nxt.wdata = s_axi_wdata_i;
			st_nxt.wstrb = s_axi_wstrb_i;
		end
		if (st_r.bvalid && s_axi_bready_i) st_nxt.bvalid = 1'b0;
		if (wr_fire) begin
			st_nxt.aw_full = 1'b0;
			st_nxt.w_full = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = cfc_pkg::RESP_OKAY;
			case (st_r.aw_idx)
				cfc_pkg::IDX_BITGRID: begin
					wr_val = cfc_merge({8'h00, st_r.bitgrid}, st_r.wdata, st_r.wstrb,
						cfc_pkg::BITGRID_MASK);
					st_nxt.bitgrid = wr_val[23:0];
				end
				cfc_pkg::IDX_PREPROC: begin
					wr_val = cfc_merge({22'h00_0000, st_r.preproc}, st_r.wdata, st_r.wstrb,
						cfc_pkg::PREPROC_MASK);
					st_nxt.preproc = wr_val[9:0];
				end
				cfc_pkg::IDX_DET_CTL: begin
					wr_val = cfc_merge({1'b0, st_r.det_store, 6'h00, st_r.hyst, st_r.target},
						st_r.wdata, st_r.wstrb, cfc_pkg::DET_CTL_MASK);
					st_nxt.det_store = wr_val[cfc_pkg::DET_STORE_BIT];
					st_nxt.hyst = wr_val[23:16];
					st_nxt.target = wr_val[15:0];
					// a new request is refused while the sequencer is busy
					if (st_r.fsm == cfc_pkg::ST_IDLE) begin
						if (wr_val[cfc_pkg::DET_STORE_BIT]) begin
							st_nxt.fsm = cfc_pkg::ST_NV_TGT;
							st_nxt.nv_req = 1'b1;
							st_nxt.nv_addr = cfc_pkg::NV_TARGET_ADDR;
							st_nxt.nv_data = wr_val[15:0];
						end else begin
							st_nxt.fsm = cfc_pkg::ST_CAL;
							st_nxt.cal_start = 1'b1;
							st_nxt.det_done = 1'b0;
						end
					end
				end
				cfc_pkg::IDX_SUPPLY: begin
					wr_val = cfc_merge({24'h00_0000, st_r.supply_cfg}, st_r.wdata, st_r.wstrb,
						cfc_pkg::SUPPLY_MASK);
					st_nxt.supply_cfg = wr_val[7:0];
				end
				cfc_pkg::IDX_NOV_CAL: begin
					wr_val = cfc_merge({30'h0000_0000, st_r.nov_trig}, st_r.wdata, st_r.wstrb,
						cfc_pkg::NOV_CAL_MASK);
					st_nxt.nov_trig = wr_val[1:0];
					if (!st_r.nov_busy) begin
						st_nxt.nov_start = 1'b1;
						st_nxt.nov_busy = 1'b1;
						st_nxt.nov_done = 1'b0;
					end
				end
				// read-only: write ignored, answered OKAY
				cfc_pkg::IDX_IQ_RES, cfc_pkg::IDX_CAL_STAT, cfc_pkg::IDX_REG_RDBK,
				cfc_pkg::IDX_FREQ, cfc_pkg::IDX_STRENGTH, cfc_pkg::IDX_INTERP: ;
				default: begin
					st_nxt.bresp = cfc_pkg::RESP_SLVERR;
				end
			endcase
		end
		// detect calibration and nonvolatile store sequencer
		case (st_r.fsm)
			cfc_pkg::ST_IDLE: ;
			cfc_pkg::ST_CAL: begin
				if (cal_done_i) begin
					st_nxt.det_done = 1'b1;
					if (cal_ok_i) st_nxt.iq = {quadrature_value_i, inphase_value_i};
					st_nxt.fsm = cfc_pkg::ST_IDLE;
				end
			end
			cfc_pkg::ST_NV_TGT: begin
				if (nv_ack_i) begin
					st_nxt.nv_addr = cfc_pkg::NV_HYST_ADDR;
					st_nxt.nv_data = {8'h00, st_r.hyst};
					st_nxt.fsm = cfc_pkg::ST_NV_HYS;
				end
			end
			cfc_pkg::ST_NV_HYS: begin
				if (nv_ack_i) begin
					st_nxt.nv_req = 1'b0;
					st_nxt.fsm = cfc_pkg::ST_IDLE;
				end
			end
			default: begin
				st_nxt.fsm = cfc_pkg::ST_IDLE;
				st_nxt.nv_req = 1'b0;
			end
		endcase
		// completion needs nov_busy already set, so an end in the same cycle as the register write is lost
		if (st_r.nov_busy && tx_offset_calib_end_i) begin
			st_nxt.nov_done = 1'b1;
			st_nxt.nov_busy = 1'b0;
		end
		// power control overrides the written setting
		st_nxt.supply_out = dynamic_power_control_en_i ?
			dynamic_power_control_setting_i : st_r.supply_cfg;
		if (!st_r.preproc[cfc_pkg::PRE_FREEZE_BIT]) st_nxt.rot_phase = rotator_phase_i;
		// read channel
		if (st_r.rvalid && s_axi_rready_i) st_nxt.rvalid = 1'b0;
		if (ar_fire) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = cfc_pkg::RESP_OKAY;
			st_nxt.rdata = 32'h0000_0000;
			case (ar_idx)
				cfc_pkg::IDX_BITGRID: st_nxt.rdata = {8'h00, st_r.bitgrid};
				cfc_pkg::IDX_PREPROC: st_nxt.rdata = {22'h00_0000, st_r.preproc};
				cfc_pkg::IDX_DET_CTL: begin
					st_nxt.rdata = {1'b0, st_r.det_store, 6'h00, st_r.hyst, st_r.target};
				end
				cfc_pkg::IDX_IQ_RES: st_nxt.rdata = st_r.iq;
				cfc_pkg::IDX_CAL_STAT: begin
					st_nxt.rdata[cfc_pkg::STAT_DET_BIT] = st_r.det_done;
					st_nxt.rdata[cfc_pkg::STAT_NOV_BIT] = st_r.nov_done;
				end
				cfc_pkg::IDX_SUPPLY: st_nxt.rdata = {24'h00_0000, st_r.supply_out};
				cfc_pkg::IDX_REG_RDBK: begin
					st_nxt.rdata = {8'h00, tx_current_measured_i, tx_supply_readback_i};
				end
				cfc_pkg::IDX_FREQ: begin
					st_nxt.rdata = {freq_fields_valid_i, 6'h00, carrier_freq_delta_i,
						7'h00, carrier_phase_i};
				end
				cfc_pkg::IDX_STRENGTH: begin
					st_nxt.rdata = {9'h000, strength_not_updating_i, carrier_freq_good_i,
						strength_fields_valid_i, latched_attenuation_i,
						strength_value_i};
				end
				cfc_pkg::IDX_INTERP: st_nxt.rdata = interpolated_strength_value_i;
				cfc_pkg::IDX_NOV_CAL: st_nxt.rdata = {30'h0000_0000, st_r.nov_trig};
				default: st_nxt.rresp = cfc_pkg::RESP_SLVERR;
			endcase
		end
		st_nxt.awready = !st_nxt.aw_full && !st_nxt.bvalid;
		st_nxt.wready = !st_nxt.w_full && !st_nxt.bvalid;
		st_nxt.arready = !st_nxt.rvalid;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st_r <= '0;
			st_r.bitgrid <= cfc_pkg::BITGRID_RST;
			st_r.preproc <= cfc_pkg::PREPROC_RST;
			st_r.supply_cfg <= cfc_pkg::SUPPLY_RST;
			st_r.supply_out <= cfc_pkg::SUPPLY_RST;
			st_r.fsm <= cfc_pkg::ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign s_axi_awready_o = st_r.awready;
	assign s_axi_wready_o = st_r.wready;
	assign s_axi_bresp_o = st_r.bresp;
	assign s_axi_bvalid_o = st_r.bvalid;
	assign s_axi_arready_o = st_r.arready;
	assign s_axi_rdata_o = st_r.rdata;
	assign s_axi_rresp_o = st_r.rresp;
	assign s_axi_rvalid_o = st_r.rvalid;
	assign threshold_half_window_o = st_r.bitgrid[23:20];
	assign threshold_update_rate_o = st_r.bitgrid[19:16];
	assign threshold_factor_min_o = st_r.bitgrid[15:10];
	assign threshold_factor_max_o = st_r.bitgrid[9:4];
	assign bitgrid_align_delay_o = st_r.bitgrid[3:0];
	assign window_start_o = st_r.preproc[2:0];
	assign window_stop_o = st_r.preproc[6:3];
	assign combiner_mode_select_o = st_r.preproc[7];
	assign sync_input_select_o = st_r.preproc[9];
	assign rotator_phase_o = st_r.rot_phase;
	assign low_power_card_detect_cal_start_o = st_r.cal_start;
	assign strength_target_o = st_r.target;
	assign strength_hysteresis_o = st_r.hyst;
	assign nv_req_o = st_r.nv_req;
	assign nv_addr_o = st_r.nv_addr;
	assign nv_data_o = st_r.nv_data;
	assign tx_offset_calib_start_o = st_r.nov_start;
	assign tx_offset_calib_trigger_o = st_r.nov_trig;
	assign tx_supply_setting_o = st_r.supply_out;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	chk_cal_start_pulse: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_fire && st_r.aw_idx == cfc_pkg::IDX_DET_CTL && st_r.fsm == cfc_pkg::ST_IDLE
		&& !wr_val[30] |=> low_power_card_detect_cal_start_o
		&& strength_target_o == $past(wr_val[15:0]) ##1 !low_power_card_detect_cal_start_o)
		else $error("calibration start not pulsed with written target");
	chk_nv_store_seq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_fire && st_r.aw_idx == cfc_pkg::IDX_DET_CTL && st_r.fsm == cfc_pkg::ST_IDLE
		&& wr_val[30] |=> nv_req_o && nv_addr_o == 16'h03E0 && !low_power_card_detect_cal_start_o)
		else $error("store request missing or wrong address");
	chk_nv_hyst_addr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r.fsm == cfc_pkg::ST_NV_TGT && nv_ack_i |=> nv_req_o && nv_addr_o == 16'h03E2
		&& nv_data_o[7:0] == strength_hysteresis_o)
		else $error("hysteresis store step wrong");
	chk_done_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r.fsm == cfc_pkg::ST_CAL && cal_done_i |=> st_r.det_done && st_r.fsm == cfc_pkg::ST_IDLE)
		else $error("detect done flag not set on completion");
	chk_iq_capture: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r.fsm == cfc_pkg::ST_CAL && cal_done_i && cal_ok_i
		|=> st_r.iq == {$past(quadrature_value_i), $past(inphase_value_i)})
		else $error("iq result not captured");
	chk_supply_mux: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		##1 tx_supply_setting_o == ($past(dynamic_power_control_en_i) ?
		$past(dynamic_power_control_setting_i) : $past(st_r.supply_cfg)))
		else $error("supply setting not selected correctly");
	chk_supply_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ar_fire && ar_idx == cfc_pkg::IDX_SUPPLY |=> s_axi_rvalid_o
		&& s_axi_rdata_o == {24'h00_0000, $past(tx_supply_setting_o)})
		else $error("supply read does not show actual setting");
	chk_freeze_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		st_r.preproc[8] |=> $stable(rotator_phase_o))
		else $error("rotator moved while frozen");
	chk_offset_start: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		wr_fire && st_r.aw_idx == cfc_pkg::IDX_NOV_CAL && !st_r.nov_busy
		|=> tx_offset_calib_start_o && !st_r.nov_done)
		else $error("offset calibration not started");
	chk_reserved_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ar_fire && ar_idx == cfc_pkg::IDX_PREPROC |=> s_axi_rdata_o[31:10] == 22'h00_0000)
		else $error("reserved bits read nonzero");

endmodule : cfc_regs

// ===== sim/testbench.sv
// testbench: self-checking bench of the calibration register bank, with a
// behavioural model of every register compared at each bus answer.
// assumes cfc_pkg is compiled first and the bank answers over AXI4-Lite.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module testbench;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [8:0] s_axi_awaddr_i = 9'h000, s_axi_araddr_i = 9'h000;
	logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
	logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
	logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o;
	logic [3:0] s_axi_wstrb_i = 4'hF;
	logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
	logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
	logic [3:0] threshold_half_window_o, threshold_update_rate_o, bitgrid_align_delay_o;
	logic [3:0] window_stop_o;
	logic [5:0] threshold_factor_min_o, threshold_factor_max_o;
	logic [2:0] window_start_o;
	logic combiner_mode_select_o, sync_input_select_o;
	logic [8:0] rotator_phase_i = 9'h000, rotator_phase_o;
	logic low_power_card_detect_cal_start_o, nv_req_o, tx_offset_calib_start_o;
	logic [15:0] strength_target_o, nv_addr_o, nv_data_o;
	logic [7:0] strength_hysteresis_o, tx_supply_setting_o;
	logic cal_done_i = 1'b0, cal_ok_i = 1'b0, nv_ack_i = 1'b0, tx_offset_calib_end_i = 1'b0;
	logic [15:0] inphase_value_i = 16'h0000, quadrature_value_i = 16'h0000;
	logic [1:0] tx_offset_calib_trigger_o;
	logic dynamic_power_control_en_i = 1'b0;
	logic [7:0] dynamic_power_control_setting_i = 8'h00, tx_supply_readback_i = 8'h00;
	logic [15:0] tx_current_measured_i = 16'h0000;
	logic freq_fields_valid_i = 1'b0, strength_fields_valid_i = 1'b0;
	logic carrier_freq_good_i = 1'b0, strength_not_updating_i = 1'b0;
	logic [8:0] carrier_freq_delta_i = 9'h000, carrier_phase_i = 9'h000;
	logic [13:0] strength_value_i = 14'h0000;
	logic [5:0] latched_attenuation_i = 6'h00;
	logic [31:0] interpolated_strength_value_i = 32'h0000_0000;

	int fail_count = 0;
	int checks_done = 0;
	int n_det = 0;
	int n_nov = 0;
	int k;
	int n;
	integer seed = 32'hC3B3;
	logic [31:0] v, w;
	// model state of the writable and result registers
	logic [31:0] m_bg, m_pre, m_ctl, m_sup, m_nov, m_iq, m_stat;
	logic [6:0] idx_map [11] = '{cfc_pkg::IDX_BITGRID, cfc_pkg::IDX_PREPROC,
		cfc_pkg::IDX_DET_CTL, cfc_pkg::IDX_IQ_RES, cfc_pkg::IDX_CAL_STAT,
		cfc_pkg::IDX_SUPPLY, cfc_pkg::IDX_REG_RDBK, cfc_pkg::IDX_FREQ,
		cfc_pkg::IDX_STRENGTH, cfc_pkg::IDX_INTERP, cfc_pkg::IDX_NOV_CAL};

	cfc_regs DUT (.*);

	always #5 clock_i = ~clock_i;

	// start pulses are counted rather than caught, so their exact cycle cannot slip past
	always @(posedge clock_i) begin
		if (low_power_card_detect_cal_start_o === 1'b1) n_det++;
		if (tx_offset_calib_start_o === 1'b1) n_nov++;
	end

	// ----------------------------------------------------------------
	// model
	// ----------------------------------------------------------------
	function automatic logic [31:0] mrd(input logic [6:0] i);
		case (i)
			cfc_pkg::IDX_BITGRID: mrd = m_bg;
			cfc_pkg::IDX_PREPROC: mrd = m_pre;
			cfc_pkg::IDX_DET_CTL: mrd = m_ctl;
			cfc_pkg::IDX_IQ_RES: mrd = m_iq;
			cfc_pkg::IDX_CAL_STAT: mrd = m_stat;
			cfc_pkg::IDX_SUPPLY: mrd = dynamic_power_control_en_i ?
				{24'h00_0000, dynamic_power_control_setting_i} : m_sup;
			cfc_pkg::IDX_REG_RDBK: mrd = {8'h00, tx_current_measured_i, tx_supply_readback_i};
			cfc_pkg::IDX_FREQ: mrd = {freq_fields_valid_i, 6'h00, carrier_freq_delta_i,
				7'h00, carrier_phase_i};
			cfc_pkg::IDX_STRENGTH: mrd = {9'h000, strength_not_updating_i, carrier_freq_good_i,
				strength_fields_valid_i, latched_attenuation_i, strength_value_i};
			cfc_pkg::IDX_INTERP: mrd = interpolated_strength_value_i;
			cfc_pkg::IDX_NOV_CAL: mrd = m_nov;
			default: mrd = 32'h0000_0000;
		endcase
	endfunction : mrd

	function automatic logic [1:0] mresp(input logic [6:0] i);
		mresp = (i inside {idx_map}) ? cfc_pkg::RESP_OKAY : cfc_pkg::RESP_SLVERR;
	endfunction : mresp

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// bus tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [6:0] i, input logic [31:0] d);
		int t;
		logic [31:0] sm;
		@(posedge clock_i);
		s_axi_awaddr_i <= {i, 2'b00};
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'b1;
		s_axi_wvalid_i <= 1'b1;
		s_axi_bready_i <= 1'b1;
		for (t = 0; t < 40; t++) begin
			@(posedge clock_i);
			if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
			if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
			if (s_axi_bvalid_o === 1'b1) break;
		end
		s_axi_bready_i <= 1'b0;
		if (t == 40) begin
			fail_count++;
			tally_and_finish();
		end else begin
			`CHK(s_axi_bresp_o, mresp(i))
			// the model merges the strobed bytes over its own old value
			sm = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}}, {8{s_axi_wstrb_i[1]}},
				{8{s_axi_wstrb_i[0]}}};
			d = (d & sm) | (mrd(i) & ~sm);
			case (i)
				cfc_pkg::IDX_BITGRID: m_bg = d & cfc_pkg::BITGRID_MASK;
				cfc_pkg::IDX_PREPROC: m_pre = d & cfc_pkg::PREPROC_MASK;
				cfc_pkg::IDX_SUPPLY: m_sup = d & cfc_pkg::SUPPLY_MASK;
				cfc_pkg::IDX_DET_CTL: begin
					m_ctl = d & cfc_pkg::DET_CTL_MASK;
					if (d[30] == 1'b0) m_stat[31] = 1'b0;
				end
				cfc_pkg::IDX_NOV_CAL: begin
					m_nov = d & cfc_pkg::NOV_CAL_MASK;
					m_stat[0] = 1'b0;
				end
				default: ;
			endcase
		end
	endtask : wr

	task automatic rd(input logic [6:0] i);
		int t;
		@(posedge clock_i);
		s_axi_araddr_i <= {i, 2'b00};
		s_axi_arvalid_i <= 1'b1;
		s_axi_rready_i <= 1'b1;
		for (t = 0; t < 40; t++) begin
			@(posedge clock_i);
			if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
			if (s_axi_rvalid_o === 1'b1) break;
		end
		s_axi_rready_i <= 1'b0;
		if (t == 40) begin
			fail_count++;
			tally_and_finish();
		end else begin
			`CHK(s_axi_rresp_o, mresp(i))
			`CHK(s_axi_rdata_o, mrd(i))
		end
	endtask : rd

	task automatic cyc(input int c);
		repeat (c) @(posedge clock_i);
	endtask : cyc

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		m_bg = 32'h0000_0000;
		m_pre = {22'h00_0000, cfc_pkg::PREPROC_RST};
		m_ctl = 32'h0000_0000;
		m_sup = 32'h0000_0000;
		m_nov = 32'h0000_0000;
		m_iq = 32'h0000_0000;
		m_stat = 32'h0000_0000;
		cyc(5);
		sys_rst_i <= 1'b0;
		cyc(2);
		for (k = 0; k < 11; k++) rd(idx_map[k]);
		rd(7'h52);
		// settings fields, reserved bits, read-only and unmapped writes
		for (k = 0; k < 4; k++) begin
			v = $random(seed);
			s_axi_wstrb_i <= v[7:4];
			wr(cfc_pkg::IDX_BITGRID, v);
			wr(cfc_pkg::IDX_PREPROC, v);
			wr(cfc_pkg::IDX_IQ_RES, v);
			wr(7'h52, v);
			rd(cfc_pkg::IDX_BITGRID);
			rd(cfc_pkg::IDX_PREPROC);
			rd(cfc_pkg::IDX_IQ_RES);
			`CHK({threshold_half_window_o, threshold_update_rate_o, threshold_factor_min_o,
				threshold_factor_max_o, bitgrid_align_delay_o}, m_bg[23:0])
			`CHK({sync_input_select_o, combiner_mode_select_o, window_stop_o, window_start_o},
				{m_pre[9], m_pre[7:0]})
		end
		s_axi_wstrb_i <= 4'hF;
		// phase rotator follows, then holds while frozen
		wr(cfc_pkg::IDX_PREPROC, 32'h0000_0000);
		rotator_phase_i <= 9'h0A5;
		cyc(3);
		`CHK(rotator_phase_o, 9'h0A5)
		wr(cfc_pkg::IDX_PREPROC, 32'h0000_0100);
		rotator_phase_i <= 9'h15A;
		cyc(3);
		`CHK(rotator_phase_o, 9'h0A5)
		// card-detect calibration, success then failure
		for (k = 0; k < 2; k++) begin
			v = $random(seed) & 32'hBFFF_FFFF;
			wr(cfc_pkg::IDX_DET_CTL, v);
			cyc(2);
			`CHK(n_det, k + 1)
			`CHK({strength_hysteresis_o, strength_target_o}, v[23:0])
			// a second control write while busy stores fields but starts nothing
			w = $random(seed) & 32'hBFFF_FFFF;
			wr(cfc_pkg::IDX_DET_CTL, w);
			`CHK(n_det, k + 1)
			rd(cfc_pkg::IDX_CAL_STAT);
			w = $random(seed);
			cal_done_i <= 1'b1;
			cal_ok_i <= (k == 0);
			{quadrature_value_i, inphase_value_i} <= w;
			@(posedge clock_i);
			cal_done_i <= 1'b0;
			m_stat[31] = 1'b1;
			if (k == 0) m_iq = w;
			cyc(2);
			rd(cfc_pkg::IDX_CAL_STAT);
			rd(cfc_pkg::IDX_IQ_RES);
			rd(cfc_pkg::IDX_DET_CTL);
		end
		// store mode: two nonvolatile words, no calibration start
		v = $random(seed) | 32'h4000_0000;
		wr(cfc_pkg::IDX_DET_CTL, v);
		for (n = 0; n < 20 && nv_req_o !== 1'b1; n++) @(posedge clock_i);
		`CHK(nv_req_o, 1'b1)
		`CHK({nv_addr_o, nv_data_o}, {cfc_pkg::NV_TARGET_ADDR, v[15:0]})
		nv_ack_i <= 1'b1;
		@(posedge clock_i);
		nv_ack_i <= 1'b0;
		cyc(2);
		`CHK({nv_req_o, nv_addr_o, nv_data_o}, {1'b1, cfc_pkg::NV_HYST_ADDR, 8'h00, v[23:16]})
		nv_ack_i <= 1'b1;
		@(posedge clock_i);
		nv_ack_i <= 1'b0;
		cyc(2);
		`CHK(nv_req_o, 1'b0)
		`CHK(n_det, 2)
		rd(cfc_pkg::IDX_CAL_STAT);
		// transmitter offset calibration
		wr(cfc_pkg::IDX_NOV_CAL, 32'hFFFF_FFFF);
		cyc(2);
		`CHK(n_nov, 1)
		`CHK(tx_offset_calib_trigger_o, 2'h3)
		rd(cfc_pkg::IDX_NOV_CAL);
		tx_offset_calib_end_i <= 1'b1;
		@(posedge clock_i);
		tx_offset_calib_end_i <= 1'b0;
		m_stat[0] = 1'b1;
		cyc(2);
		rd(cfc_pkg::IDX_CAL_STAT);
		// supply setting with power control off and on
		for (k = 0; k < 4; k++) begin
			v = $random(seed);
			dynamic_power_control_en_i <= k[0];
			dynamic_power_control_setting_i <= v[15:8];
			wr(cfc_pkg::IDX_SUPPLY, v);
			cyc(2);
			`CHK(tx_supply_setting_o, k[0] ? v[15:8] : v[7:0])
			rd(cfc_pkg::IDX_SUPPLY);
		end
		// live measurement readback
		for (k = 0; k < 4; k++) begin
			v = $random(seed);
			w = $random(seed);
			{tx_current_measured_i, tx_supply_readback_i} <= v[23:0];
			{freq_fields_valid_i, carrier_freq_delta_i, carrier_phase_i} <= w[18:0];
			{strength_not_updating_i, carrier_freq_good_i, strength_fields_valid_i} <= v[31:29];
			{latched_attenuation_i, strength_value_i} <= w[31:12];
			interpolated_strength_value_i <= v ^ w;
			@(posedge clock_i);
			rd(cfc_pkg::IDX_REG_RDBK);
			rd(cfc_pkg::IDX_FREQ);
			rd(cfc_pkg::IDX_STRENGTH);
			rd(cfc_pkg::IDX_INTERP);
		end
		tally_and_finish();
	end
endmodule : testbench
